// File: rtl/wor_option_reg.v
// write-once system option register with wishbone slave
// How it works
// - reset default, first write only sticks
// - nine low cycles trip detector reset
// - stop option keeps detector alive in stop
// - stop running needs power and stop bits
// - reset bit gates detector reset out
// - power bit powers the detector
// - stop recovery 32 or 4096 crystal cycles
// - watchdog period short or long select
// - stop bit clear makes stop illegal
// - disable bit turns watchdog off
`timescale 1ns/1ps
`include "wor_map.vh"
module wor_option_reg (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output reg         err_o,
  input  wire        stop_mode_i,
  input  wire        stop_opcode_i,
  input  wire        lv_below_fall_i,
  input  wire        lv_above_rise_i,
  output reg         low_voltage_power_enable_o,
  output reg         low_voltage_stop_enable_o,
  output reg         low_voltage_detector_active_o,
  output reg         low_voltage_reset_o,
  output reg         short_recovery_select_o,
  output reg  [12:0] stop_recovery_cycles_o,
  output reg         watchdog_period_select_o,
  output reg  [18:0] watchdog_timeout_cycles_o,
  output reg         watchdog_disable_o,
  output reg         watchdog_enable_o,
  output reg         stop_enable_o,
  output reg         illegal_stop_o
);
  // ==================================================
  // register state
  reg  [7:0] config_val;
  reg        locked;
  wire       lv_trip;
  wire       req;
  wire       hit_cfg;
  wire       hit_sts;
  wire       good;
  wire [7:0] next_config;

  function bit_of;
    input [7:0] v;
    input integer i;
    begin
      bit_of = v[i];
    end
  endfunction

  assign req     = cyc_i & stb_i & ~ack_o & ~err_o;
  assign hit_cfg = adr_i == `WOR_ADR_CONFIG;
  assign hit_sts = adr_i == `WOR_ADR_STATUS;
  assign good    = hit_cfg | hit_sts;
  assign next_config = dat_i[7:0];

  // ==================================================
  // wishbone slave, one registered ack after one wait state
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o      <= 1'b0;
      err_o      <= 1'b0;
      dat_o      <= `WOR_DATA_ZERO;
      config_val <= `WOR_CFG_RESET;
      locked     <= 1'b0;
    end else begin
      ack_o <= req & good;
      err_o <= req & ~good;
      dat_o <= `WOR_DATA_ZERO;
      if (req && hit_cfg && !we_i)
        dat_o <= {24'h000000, config_val};
      if (req && hit_sts && !we_i)
        dat_o <= {31'h00000000, locked};
      if (req && hit_cfg && we_i && !locked) begin
        locked <= 1'b1;
        if (sel_i[0])
          config_val <= next_config;
      end
    end
  end

  // ==================================================
  // option bits routed to their modules
  wor_lv_filter u_filter (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .active_i     (low_voltage_detector_active_o),
    .below_fall_i (lv_below_fall_i),
    .above_rise_i (lv_above_rise_i),
    .trip_o       (lv_trip)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      low_voltage_power_enable_o    <= 1'b0;
      low_voltage_stop_enable_o     <= 1'b0;
      low_voltage_detector_active_o <= 1'b0;
      low_voltage_reset_o           <= 1'b0;
      short_recovery_select_o       <= 1'b0;
      stop_recovery_cycles_o        <= `WOR_REC_LONG;
      watchdog_period_select_o      <= 1'b0;
      watchdog_timeout_cycles_o     <= `WOR_WDG_LONG;
      watchdog_disable_o            <= 1'b0;
      watchdog_enable_o             <= 1'b0;
      stop_enable_o                 <= 1'b0;
      illegal_stop_o                <= 1'b0;
    end else begin
      low_voltage_power_enable_o <=
        bit_of(config_val, `WOR_BIT_LV_PWR);
      low_voltage_stop_enable_o  <=
        bit_of(config_val, `WOR_BIT_LV_STOP);
      low_voltage_detector_active_o <=
        bit_of(config_val, `WOR_BIT_LV_PWR) &
        (~stop_mode_i |
         bit_of(config_val, `WOR_BIT_LV_STOP));
      low_voltage_reset_o <=
        lv_trip & bit_of(config_val, `WOR_BIT_LV_RST);
      short_recovery_select_o <=
        bit_of(config_val, `WOR_BIT_SHORT_REC);
      stop_recovery_cycles_o <=
        bit_of(config_val, `WOR_BIT_SHORT_REC) ?
        `WOR_REC_SHORT : `WOR_REC_LONG;
      watchdog_period_select_o <=
        bit_of(config_val, `WOR_BIT_WDG_PER);
      watchdog_timeout_cycles_o <=
        bit_of(config_val, `WOR_BIT_WDG_PER) ?
        `WOR_WDG_SHORT : `WOR_WDG_LONG;
      watchdog_disable_o <=
        bit_of(config_val, `WOR_BIT_WDG_DIS);
      watchdog_enable_o <=
        ~bit_of(config_val, `WOR_BIT_WDG_DIS);
      stop_enable_o <= bit_of(config_val, `WOR_BIT_STOP_EN);
      illegal_stop_o <= stop_opcode_i &
        ~bit_of(config_val, `WOR_BIT_STOP_EN);
    end
  end
endmodule // wor_option_reg

// File: rtl/wor_map.vh
// register offsets, bit positions, reset values and timing counts
`ifndef WOR_MAP_VH
`define WOR_MAP_VH

`define WOR_ADR_CONFIG      4'h0
`define WOR_ADR_STATUS      4'h4
`define WOR_ADR_LOW         2'h0
`define WOR_CFG_RESET       8'h00

`define WOR_BIT_WDG_DIS     0
`define WOR_BIT_STOP_EN     1
`define WOR_BIT_WDG_PER     2
`define WOR_BIT_SHORT_REC   3
`define WOR_BIT_LV_PWR      4
`define WOR_BIT_LV_RST      5
`define WOR_BIT_LV_STOP     6

`define WOR_LV_FILTER       4'h9
`define WOR_REC_SHORT       13'h0020
`define WOR_REC_LONG        13'h1000
`define WOR_WDG_SHORT       19'h01FF0
`define WOR_WDG_LONG        19'h3FFF0
`define WOR_DATA_ZERO       32'h00000000

`endif

// File: rtl/wor_lv_filter.v
// low-voltage filter: nine consecutive low samples assert reset
`timescale 1ns/1ps
`include "wor_map.vh"
module wor_lv_filter (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       active_i,
  input  wire       below_fall_i,
  input  wire       above_rise_i,
  output reg        trip_o
);
  reg [3:0] run;

  always @(posedge clk_i) begin
    if (rst_i) begin
      run    <= 4'h0;
      trip_o <= 1'b0;
    end else if (!active_i) begin
      run    <= 4'h0;
      trip_o <= 1'b0;
    end else begin
      if (!below_fall_i)
        run <= 4'h0;
      else if (run != `WOR_LV_FILTER)
        run <= run + 4'h1;
      if (trip_o && above_rise_i)
        trip_o <= 1'b0;
      else if (below_fall_i && run == `WOR_LV_FILTER - 4'h1)
        trip_o <= 1'b1;
    end
  end
endmodule // wor_lv_filter

// File: sim/wor_chk_props.sv
// assertion checker for the option register
`timescale 1ns/1ps
module wor_chk (
  input wire        clk_i, rst_i, cyc_i, stb_i, ack_o, err_o,
  input wire        stop_opcode_i, stop_enable_o, illegal_stop_o,
  input wire        watchdog_enable_o, watchdog_disable_o,
  input wire        short_recovery_select_o, watchdog_period_select_o,
  input wire [3:0]  adr_i,
  input wire [12:0] stop_recovery_cycles_o,
  input wire [18:0] watchdog_timeout_cycles_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; cyc_i && stb_i && !ack_o && !err_o; endsequence
  property p_ans; s_req |=> ack_o ^ err_o; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; ack_o |=> !ack_o; endproperty
  a_one: assert property (p_one) else $error("long ack");
  property p_err; err_o |=> !err_o && !ack_o; endproperty
  a_err: assert property (p_err) else $error("long err");
  property p_map; err_o |-> $past(adr_i) != 4'h0; endproperty
  a_map: assert property (p_map) else $error("err on config");
  property p_wdg;
    !$past(rst_i) |-> watchdog_enable_o != watchdog_disable_o;
  endproperty
  a_wdg: assert property (p_wdg) else $error("watchdog enable");
  property p_rec; stop_recovery_cycles_o ==
    (short_recovery_select_o ? 13'h0020 : 13'h1000); endproperty
  a_rec: assert property (p_rec) else $error("recovery");
  property p_tmo; watchdog_timeout_cycles_o ==
    (watchdog_period_select_o ? 19'h01FF0 : 19'h3FFF0); endproperty
  a_tmo: assert property (p_tmo) else $error("timeout");
  property p_ill; !$past(rst_i) |->
    illegal_stop_o == ($past(stop_opcode_i) && !stop_enable_o); endproperty
  a_ill: assert property (p_ill) else $error("illegal stop");
endmodule // wor_chk
bind wor_option_reg wor_chk u_wor_chk (.*);

// File: sim/tb_top.sv
// bench for the write-once option register
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, er;
  logic stop_mode_i = 0, stop_opcode_i = 0;
  logic lv_below_fall_i = 0, lv_above_rise_i = 0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, q;
  wire [31:0] dat_o;
  wire [12:0] stop_recovery_cycles_o;
  wire [18:0] watchdog_timeout_cycles_o;
  wire ack_o, err_o, stop_enable_o, illegal_stop_o;
  wire watchdog_disable_o, watchdog_enable_o;
  wire short_recovery_select_o, watchdog_period_select_o;
  wire low_voltage_power_enable_o, low_voltage_stop_enable_o;
  wire low_voltage_detector_active_o, low_voltage_reset_o;
  int n_fail = 0, check_count = 0;
  // first row: short recovery clear, as with a crystal source
  logic [39:0] rows [4] = '{{8'h00, 13'h1000, 19'h3FFF0},
    {8'h7F, 13'h0020, 19'h01FF0}, {8'h0A, 13'h0020, 19'h3FFF0},
    {8'h55, 13'h1000, 19'h01FF0}};
  wor_option_reg u_wor_option_reg (.*);
  always #5 clk_i = ~clk_i;
  task finish_test;
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %0t got %h want %h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (!(ack_o | err_o) && k < 20);
    q = dat_o;
    er = err_o;
    if (k == 20) begin
      n_fail++;
      finish_test;
    end
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  task rst;
    rst_i <= 1;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
  endtask
  initial begin
    foreach (rows[i]) begin
      rst;
      bus(0, 4'h0, 8'h00);
      chk(q, 0);
      bus(1, 4'h0, rows[i][39:32]);
      bus(1, 4'h0, ~rows[i][39:32]);
      stop_mode_i <= 1;
      stop_opcode_i <= 1;
      bus(0, 4'h0, 8'h00);
      chk(q, rows[i][39:32]);
      chk(stop_recovery_cycles_o, rows[i][31:19]);
      chk(watchdog_timeout_cycles_o, rows[i][18:0]);
      chk(watchdog_enable_o, !rows[i][32]);
      chk(illegal_stop_o, !rows[i][33]);
      chk(low_voltage_power_enable_o, rows[i][36]);
      chk(low_voltage_detector_active_o, rows[i][36] & rows[i][38]);
      chk(watchdog_disable_o, rows[i][32]);
      chk(stop_enable_o, rows[i][33]);
      chk(watchdog_period_select_o, rows[i][34]);
      chk(short_recovery_select_o, rows[i][35]);
      chk(low_voltage_stop_enable_o, rows[i][38]);
      stop_mode_i <= 0;
      stop_opcode_i <= 0;
      bus(0, 4'h4, 8'h00);
      chk(q, 1);
      chk(low_voltage_detector_active_o, rows[i][36]);
      chk(illegal_stop_o, 0);
    end
    rst;
    bus(1, 4'h8, 8'h00);
    chk(er, 1);
    bus(1, 4'h0, 8'h30);
    lv_below_fall_i <= 1;
    repeat (8) @(posedge clk_i);
    lv_below_fall_i <= 0;
    repeat (3) @(posedge clk_i);
    chk(low_voltage_reset_o, 0);
    lv_below_fall_i <= 1;
    repeat (11) @(posedge clk_i);
    chk(low_voltage_reset_o, 1);
    lv_below_fall_i <= 0;
    lv_above_rise_i <= 1;
    repeat (3) @(posedge clk_i);
    chk(low_voltage_reset_o, 0);
    rst;
    bus(1, 4'h0, 8'h10);
    lv_above_rise_i <= 0;
    lv_below_fall_i <= 1;
    repeat (11) @(posedge clk_i);
    chk(low_voltage_reset_o, 0);
    lv_below_fall_i <= 0;
    finish_test;
  end
endmodule // tb_top
